// ---- core/smt_defs.svh ----
// Register offsets, field positions and reset values of the measurement timer.
`ifndef SMT_DEFS_SVH
`define SMT_DEFS_SVH
`define SMT_ADDR_W         4
`define SMT_OFF_CON0       4'h0
`define SMT_OFF_CON1       4'h1
`define SMT_OFF_STAT       4'h2
`define SMT_OFF_TMR        4'h3
`define SMT_OFF_CPW        4'h4
`define SMT_OFF_CPR        4'h5
`define SMT_OFF_PR         4'h6
`define SMT_OFF_IRQ_STAT   4'h7
`define SMT_OFF_IRQ_MASK   4'h8
`define SMT_CON0_PS_LO     0
`define SMT_CON0_PS_HI     1
`define SMT_CON0_CPOL      2
`define SMT_CON0_SPOL      3
`define SMT_CON0_WPOL      4
`define SMT_CON0_HALT      5
`define SMT_CON1_GO        7
`define SMT_CON1_MODE_LO   0
`define SMT_CON1_MODE_HI   3
`define SMT_STAT_PRUP      0
`define SMT_STAT_PWUP      1
`define SMT_STAT_RST       2
`define SMT_STAT_SIG       5
`define SMT_STAT_WIN       6
`define SMT_STAT_TS        7
`define SMT_IRQ_PM         0
`define SMT_IRQ_PW         1
`define SMT_IRQ_PR         2
`define SMT_CNT_RST        24'h00_0000
`define SMT_PR_RST         24'hFF_FFFF
`endif

// ---- core/smt_pkg.sv ----
// Types shared by the measurement timer core.
package smt_pkg;
    typedef logic [23:0] smt_cnt_t;
    typedef enum logic [3:0] {
        SMT_MODE_TIMER, SMT_MODE_GATED, SMT_MODE_PW, SMT_MODE_PERIOD,
        SMT_MODE_DUTY, SMT_MODE_HILO, SMT_MODE_WINMEAS, SMT_MODE_GATEDWIN,
        SMT_MODE_TOF, SMT_MODE_CAPTURE, SMT_MODE_COUNTER, SMT_MODE_GATEDCNT,
        SMT_MODE_WINCNT, SMT_MODE_RSV13, SMT_MODE_RSV14, SMT_MODE_RSV15
    } smt_mode_e;
endpackage

// ---- core/smt_core.sv ----
// Measurement timer core: counter, latches, halt, polarity and status with a register port.
`timescale 1ns/10ps
`default_nettype none
`include "smt_defs.svh"
// Behaviour
// - The 24-bit measurement counter is forced to zero when the counter clear request is set, unless a counter write lands in the same cycle.
// - The pulse width latch captures the counter on its mode-dependent trigger.
// - Setting the pulse width snapshot request copies the counter into the pulse width latch.
// - The period latch captures the counter on its own, distinct mode-dependent trigger.
// - Setting the period snapshot request copies the counter into the period latch.
// - With rollover halt set the counter does not roll over to zero on a period match.
// - With halt set the period match interrupt persists until clear request or stop-and-rewrite.
// - Window, signal and clock inputs each have a polarity bit in control register zero.
// - Input status flags show the inputs after polarity correction.
// - The window level flag is driven only in windowed, gated counter and gated window modes.
// - The signal level flag is driven except in window measure, time of flight and capture.
// - In every mode a counter equal to the period limit raises period match and, with halt clear, rolls to zero.
// - Counter and input synchronisers advance on the prescaled selected clock.
module smt_core #(
    parameter int CNT_W = 24
) (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic [`SMT_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire logic                     clk_src,
    input  wire logic                     win_in,
    input  wire logic                     sig_in,
    input  wire logic                     pw_trig,
    input  wire logic                     pr_trig,
    output logic                          irq
);
    import smt_pkg::*;

    initial begin
        if (CNT_W != 24) begin
            $error("smt_core serves only a 24-bit counter");
        end
    end

    typedef struct packed {
        logic [7:0]  con0;
        logic [7:0]  con1;
        logic [2:0]  req;
        smt_cnt_t    cnt;
        smt_cnt_t    cpw;
        smt_cnt_t    cpr;
        smt_cnt_t    pr;
        logic [2:0]  ist;
        logic [2:0]  imsk;
        logic [2:0]  pre;
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_prev;
        logic        win_s1;
        logic        win_s2;
        logic        sig_s1;
        logic        sig_s2;
        logic        win_flag;
        logic        sig_flag;
        logic        ts;
        logic        hold_pm;
        logic [31:0] rdata;
    } smt_state_s;

    smt_state_s s_q;
    smt_state_s s_d;

    function automatic logic win_mode(input smt_mode_e m);
        return m == SMT_MODE_WINMEAS || m == SMT_MODE_GATEDCNT || m == SMT_MODE_GATEDWIN
            || m == SMT_MODE_WINCNT;
    endfunction

    function automatic logic sig_mode(input smt_mode_e m);
        return !(m == SMT_MODE_WINMEAS || m == SMT_MODE_TOF || m == SMT_MODE_CAPTURE);
    endfunction

    logic       clk_edge;
    logic       tick;
    logic       go;
    logic       halt;
    logic       match;
    logic [2:0] ps_mask;
    smt_mode_e  mode;

    always_comb begin
        go       = s_q.con1[`SMT_CON1_GO];
        halt     = s_q.con0[`SMT_CON0_HALT];
        mode     = smt_mode_e'(s_q.con1[`SMT_CON1_MODE_HI:`SMT_CON1_MODE_LO]);
        // Polarity picks the rising or falling edge of the clock source.
        clk_edge = (s_q.clk_s2 ^ s_q.con0[`SMT_CON0_CPOL])
                 & ~(s_q.clk_prev ^ s_q.con0[`SMT_CON0_CPOL]);
        // Prescale 1, 2, 4 or 8 of the clock edges.
        unique case (s_q.con0[`SMT_CON0_PS_HI:`SMT_CON0_PS_LO])
            2'd0: ps_mask = 3'h0;
            2'd1: ps_mask = 3'h1;
            2'd2: ps_mask = 3'h3;
            2'd3: ps_mask = 3'h7;
        endcase
        tick  = clk_edge && ((s_q.pre & ps_mask) == ps_mask);
        match = s_q.cnt == s_q.pr;
    end

    always_comb begin
        s_d          = s_q;
        s_d.rdata    = 32'h0000_0000;
        s_d.clk_s1   = clk_src;
        s_d.clk_s2   = s_q.clk_s1;
        s_d.clk_prev = s_q.clk_s2;
        if (clk_edge) begin
            s_d.pre = s_q.pre + 3'h1;
        end
        // Input synchronisers move on the prescaled clock, hence the lag in every mode.
        if (tick) begin
            s_d.win_s1 = win_in ^ s_q.con0[`SMT_CON0_WPOL];
            s_d.win_s2 = s_q.win_s1;
            s_d.sig_s1 = sig_in ^ s_q.con0[`SMT_CON0_SPOL];
            s_d.sig_s2 = s_q.sig_s1;
        end
        s_d.ts       = go;
        s_d.win_flag = win_mode(mode) ? s_q.win_s2 : 1'b0;
        s_d.sig_flag = sig_mode(mode) ? s_q.sig_s2 : 1'b0;
        // Counter advance, with rollover or halt at the period limit.
        if (tick && go) begin
            if (match) begin
                s_d.ist[`SMT_IRQ_PM] = 1'b1;
                if (halt) begin
                    s_d.hold_pm = 1'b1;
                end else begin
                    s_d.cnt = `SMT_CNT_RST;
                end
            end else begin
                s_d.cnt = s_q.cnt + 24'h00_0001;
            end
        end
        if (pw_trig) begin
            s_d.cpw = s_q.cnt;
        end
        if (pr_trig) begin
            s_d.cpr = s_q.cnt;
        end
        // Requests act one cycle after being written, then drop.
        if (s_q.req[`SMT_STAT_RST]) begin
            s_d.cnt     = `SMT_CNT_RST;
            s_d.hold_pm = 1'b0;
        end
        if (s_q.req[`SMT_STAT_PWUP]) begin
            s_d.cpw = s_q.cnt;
        end
        if (s_q.req[`SMT_STAT_PRUP]) begin
            s_d.cpr = s_q.cnt;
        end
        s_d.req = 3'h0;
        if (reg_wr) begin
            unique case (reg_addr)
                `SMT_OFF_CON0: s_d.con0 = reg_wdata[7:0];
                `SMT_OFF_CON1: s_d.con1 = reg_wdata[7:0];
                `SMT_OFF_STAT: s_d.req  = reg_wdata[2:0];
                `SMT_OFF_TMR: begin
                    // Counter writes override counting and a clear request in the same cycle.
                    s_d.cnt = reg_wdata[23:0];
                    if (!go) begin
                        s_d.hold_pm = 1'b0;
                    end
                end
                `SMT_OFF_PR:       s_d.pr   = reg_wdata[23:0];
                `SMT_OFF_IRQ_STAT: s_d.ist  = s_d.ist & ~(reg_wdata[2:0] & ~(s_d.ist & ~s_q.ist));
                `SMT_OFF_IRQ_MASK: s_d.imsk = reg_wdata[2:0];
                default: ;
            endcase
        end
        // A held match keeps its flag raised even against a write-one clear, so it follows it.
        if (s_q.hold_pm) begin
            s_d.ist[`SMT_IRQ_PM] = 1'b1;
        end
        // Latch captures count as events.
        if (pw_trig || s_q.req[`SMT_STAT_PWUP]) begin
            s_d.ist[`SMT_IRQ_PW] = 1'b1;
        end
        if (pr_trig || s_q.req[`SMT_STAT_PRUP]) begin
            s_d.ist[`SMT_IRQ_PR] = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `SMT_OFF_CON0:     s_d.rdata = {24'h00_0000, s_q.con0};
                `SMT_OFF_CON1:     s_d.rdata = {24'h00_0000, s_q.con1};
                `SMT_OFF_STAT:     s_d.rdata = {24'h00_0000, s_q.ts, s_q.win_flag,
                                                s_q.sig_flag, 2'b00, s_q.req};
                `SMT_OFF_TMR:      s_d.rdata = {8'h00, s_q.cnt};
                `SMT_OFF_CPW:      s_d.rdata = {8'h00, s_q.cpw};
                `SMT_OFF_CPR:      s_d.rdata = {8'h00, s_q.cpr};
                `SMT_OFF_PR:       s_d.rdata = {8'h00, s_q.pr};
                `SMT_OFF_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.ist};
                `SMT_OFF_IRQ_MASK: s_d.rdata = {29'h0000_0000, s_q.imsk};
                default:           s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_q      <= '0;
            s_q.pr   <= `SMT_PR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq       = |(s_q.ist & s_q.imsk);

    property p_clear_req;
        @(posedge mclk) disable iff (!reset_n)
        (reg_wr && reg_addr == `SMT_OFF_STAT && reg_wdata[`SMT_STAT_RST])
        ##1 !reg_wr |=> s_q.cnt == 24'h00_0000;
    endproperty
    a_clear_req: assert property (p_clear_req) else $error("clear request missed");

    property p_pw_snap;
        @(posedge mclk) disable iff (!reset_n)
        (s_q.req[`SMT_STAT_PWUP] && !pw_trig) |=> s_q.cpw == $past(s_q.cnt);
    endproperty
    a_pw_snap: assert property (p_pw_snap) else $error("pulse width snapshot wrong");

    property p_pw_trig;
        @(posedge mclk) disable iff (!reset_n)
        pw_trig |=> s_q.cpw == $past(s_q.cnt);
    endproperty
    a_pw_trig: assert property (p_pw_trig) else $error("pulse width capture wrong");

    property p_pr_snap;
        @(posedge mclk) disable iff (!reset_n)
        (s_q.req[`SMT_STAT_PRUP] || pr_trig) |=> s_q.cpr == $past(s_q.cnt);
    endproperty
    a_pr_snap: assert property (p_pr_snap) else $error("period capture wrong");

    property p_req_self_clear;
        @(posedge mclk) disable iff (!reset_n)
        (s_q.req != 3'h0) |=> (s_q.req == 3'h0 || $past(reg_wr));
    endproperty
    a_req_self_clear: assert property (p_req_self_clear) else $error("request stuck");

    property p_halt;
        @(posedge mclk) disable iff (!reset_n)
        (tick && go && match && halt && !s_q.req[`SMT_STAT_RST] && !reg_wr)
        |=> s_q.cnt == $past(s_q.cnt) && s_q.hold_pm;
    endproperty
    a_halt: assert property (p_halt) else $error("halted counter rolled over");

    property p_hold_pm;
        @(posedge mclk) disable iff (!reset_n)
        s_q.hold_pm |=> s_q.ist[`SMT_IRQ_PM];
    endproperty
    a_hold_pm: assert property (p_hold_pm) else $error("held match dropped");

    property p_rollover;
        @(posedge mclk) disable iff (!reset_n)
        (tick && go && match && !halt && !reg_wr)
        |=> s_q.cnt == 24'h00_0000 && s_q.ist[`SMT_IRQ_PM];
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover missed");

    property p_hold_idle;
        @(posedge mclk) disable iff (!reset_n)
        (!go && !reg_wr && !s_q.req[`SMT_STAT_RST]) |=> s_q.cnt == $past(s_q.cnt);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("counter moved while stopped");

    property p_win_flag;
        @(posedge mclk) disable iff (!reset_n)
        !win_mode(mode) |=> !s_q.win_flag;
    endproperty
    a_win_flag: assert property (p_win_flag) else $error("window flag outside its modes");

    property p_sig_flag;
        @(posedge mclk) disable iff (!reset_n)
        sig_mode(mode) |=> s_q.sig_flag == $past(s_q.sig_s2);
    endproperty
    a_sig_flag: assert property (p_sig_flag) else $error("signal flag not corrected");

    sequence s_pm_clear_write;
        reg_wr && reg_addr == `SMT_OFF_IRQ_STAT && reg_wdata[`SMT_IRQ_PM];
    endsequence

    property p_hold_beats_clear;
        @(posedge mclk) disable iff (!reset_n)
        s_q.hold_pm ##0 s_pm_clear_write |=> s_q.ist[`SMT_IRQ_PM];
    endproperty
    a_hold_beats_clear: assert property (p_hold_beats_clear) else $error("held match cleared");

    property p_pr_trig;
        @(posedge mclk) disable iff (!reset_n)
        pr_trig |=> s_q.cpr == $past(s_q.cnt);
    endproperty
    a_pr_trig: assert property (p_pr_trig) else $error("period trigger capture wrong");

    property p_cnt_step;
        @(posedge mclk) disable iff (!reset_n)
        (tick && go && !match && !reg_wr && !s_q.req[`SMT_STAT_RST])
        |=> s_q.cnt == $past(s_q.cnt) + 24'h00_0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not advance");

    property p_win_sync;
        @(posedge mclk) disable iff (!reset_n)
        tick |=> s_q.win_s1 == ($past(win_in) ^ $past(s_q.con0[`SMT_CON0_WPOL]));
    endproperty
    a_win_sync: assert property (p_win_sync) else $error("window polarity wrong");

    property p_sig_sync;
        @(posedge mclk) disable iff (!reset_n)
        tick |=> s_q.sig_s1 == ($past(sig_in) ^ $past(s_q.con0[`SMT_CON0_SPOL]));
    endproperty
    a_sig_sync: assert property (p_sig_sync) else $error("signal polarity wrong");

    property p_clk_pol;
        @(posedge mclk) disable iff (!reset_n)
        clk_edge |-> s_q.clk_s2 != s_q.clk_prev && s_q.clk_s2 == !s_q.con0[`SMT_CON0_CPOL];
    endproperty
    a_clk_pol: assert property (p_clk_pol) else $error("clock edge polarity wrong");

    property p_status_valid;
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> s_q.ts == $past(go);
    endproperty
    a_status_valid: assert property (p_status_valid) else $error("status valid wrong");

    property p_pre_count;
        @(posedge mclk) disable iff (!reset_n)
        clk_edge |=> s_q.pre == $past(s_q.pre) + 3'h1;
    endproperty
    a_pre_count: assert property (p_pre_count) else $error("prescaler missed an edge");

    property p_pm_on_match;
        @(posedge mclk) disable iff (!reset_n)
        (tick && go && match) |=> s_q.ist[`SMT_IRQ_PM] || $past(reg_wr);
    endproperty
    a_pm_on_match: assert property (p_pm_on_match) else $error("period match missed");

endmodule // smt_core
`default_nettype wire

// ---- test/smt_src_model.sv ----
// Model of the clock, window and signal sources feeding the measurement timer.
`timescale 1ns/10ps
`default_nettype none
module smt_src_model (
    input  wire logic mclk,
    output logic      clk_src,
    output logic      win_in,
    output logic      sig_in
);
    initial begin
        clk_src = 1'b0;
        win_in  = 1'b0;
        sig_in  = 1'b0;
    end
    // The source clock rests low between bursts, so no stray edge is ever counted.
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge mclk);
            clk_src <= 1'b1;
            repeat (3) @(posedge mclk);
            clk_src <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        // Settling time covers the clock synchroniser and the last counter update before anyone reads back.
        repeat (8) @(posedge mclk);
    endtask
    task automatic set_lv(input logic w, input logic s);
        @(posedge mclk);
        win_in <= w;
        sig_in <= s;
    endtask
endmodule // smt_src_model
`default_nettype wire

// ---- test/measurement_timer_core_test.sv ----
// Self-checking testbench of the measurement timer core.
`timescale 1ns/10ps
`default_nettype none
`include "smt_defs.svh"
module measurement_timer_core_test;
    import smt_pkg::*;
    typedef struct {logic rw; logic [3:0] a; logic [31:0] w; logic [31:0] e;} smt_row_s;
    logic        mclk, reset_n, reg_wr, reg_rd, pw_trig, pr_trig;
    logic        clk_src, win_in, sig_in, irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    int          n_fail, num_checks;
    smt_row_s    rows[16] = '{
        '{0, 4'h0, 32'h0, 32'h0}, '{0, 4'h1, 32'h0, 32'h0}, '{0, 4'h2, 32'h0, 32'h0},
        '{0, 4'h3, 32'h0, 32'h0}, '{0, 4'h4, 32'h0, 32'h0}, '{0, 4'h5, 32'h0, 32'h0},
        '{0, 4'h6, 32'h0, 32'hFF_FFFF}, '{0, 4'h7, 32'h0, 32'h0},
        '{0, 4'h8, 32'h0, 32'h0}, '{0, 4'h9, 32'h0, 32'h0},
        '{1, 4'h0, 32'h3F, 32'h3F}, '{1, 4'h1, 32'h5, 32'h5},
        '{1, 4'h3, 32'h12_3456, 32'h12_3456}, '{1, 4'h6, 32'h10, 32'h10},
        '{1, 4'h8, 32'h7, 32'h7}, '{1, 4'h9, 32'h55, 32'h0}};

    smt_core u_smt_core (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clk_src(clk_src), .win_in(win_in), .sig_in(sig_in), .pw_trig(pw_trig),
        .pr_trig(pr_trig), .irq(irq));
    smt_src_model u_smt_src_model (.mclk(mclk), .clk_src(clk_src), .win_in(win_in),
        .sig_in(sig_in));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask
    task automatic rst();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    task automatic trig(input logic pw);
        @(posedge mclk);
        if (pw) pw_trig <= 1'b1;
        else pr_trig <= 1'b1;
        @(posedge mclk);
        pw_trig <= 1'b0;
        pr_trig <= 1'b0;
    endtask

    initial begin
        #900_000;
        n_fail++;
        give_verdict();
    end
    initial begin
        reset_n   = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        pw_trig   = 1'b0;
        pr_trig   = 1'b0;
        n_fail    = 0;
        num_checks = 0;
        rst();
        foreach (rows[i]) begin
            if (rows[i].rw) wr(rows[i].a, rows[i].w);
            rchk("reg", rows[i].a, rows[i].e);
        end
        chk("irq_masked_idle", 32'h0, {31'h0, irq});
        // Eight source pulses bring the prescaler back to phase zero at every setting.
        for (int ps = 0; ps < 4; ps++) begin
            rst();
            wr(`SMT_OFF_CON0, 32'(ps));
            wr(`SMT_OFF_CON1, 32'h80);
            u_smt_src_model.burst(8);
            rchk("tick", `SMT_OFF_TMR, 32'(8 >> ps));
            wr(`SMT_OFF_CON1, 32'h0);
            u_smt_src_model.burst(8);
            rchk("hold", `SMT_OFF_TMR, 32'(8 >> ps));
        end
        wr(`SMT_OFF_TMR, 32'hA5_5A5A);
        wr(`SMT_OFF_STAT, 32'h3);
        rchk("pw_snap", `SMT_OFF_CPW, 32'hA5_5A5A);
        rchk("pr_snap", `SMT_OFF_CPR, 32'hA5_5A5A);
        rchk("req_clr", `SMT_OFF_STAT, 32'h0);
        wr(`SMT_OFF_STAT, 32'h4);
        rchk("cnt_clr", `SMT_OFF_TMR, 32'h0);
        rchk("rst_clr", `SMT_OFF_STAT, 32'h0);
        wr(`SMT_OFF_TMR, 32'h11);
        trig(1'b1);
        wr(`SMT_OFF_TMR, 32'h22);
        trig(1'b0);
        rchk("pw_cap", `SMT_OFF_CPW, 32'h11);
        rchk("pr_cap", `SMT_OFF_CPR, 32'h22);
        rchk("cap_irq", `SMT_OFF_IRQ_STAT, 32'h6);
        wr(`SMT_OFF_IRQ_STAT, 32'h6);
        rchk("w1c", `SMT_OFF_IRQ_STAT, 32'h0);
        rst();
        wr(`SMT_OFF_PR, 32'h3);
        wr(`SMT_OFF_IRQ_MASK, 32'h1);
        wr(`SMT_OFF_CON1, 32'h80);
        u_smt_src_model.burst(4);
        rchk("roll", `SMT_OFF_TMR, 32'h0);
        rchk("match", `SMT_OFF_IRQ_STAT, 32'h1);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(`SMT_OFF_IRQ_MASK, 32'h0);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(`SMT_OFF_IRQ_STAT, 32'h1);
        wr(`SMT_OFF_IRQ_MASK, 32'h1);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(`SMT_OFF_CON0, 32'h20);
        u_smt_src_model.burst(6);
        rchk("halt", `SMT_OFF_TMR, 32'h3);
        wr(`SMT_OFF_IRQ_STAT, 32'h1);
        rchk("held", `SMT_OFF_IRQ_STAT, 32'h1);
        wr(`SMT_OFF_STAT, 32'h4);
        wr(`SMT_OFF_IRQ_STAT, 32'h1);
        rchk("rel_clr", `SMT_OFF_IRQ_STAT, 32'h0);
        u_smt_src_model.burst(4);
        wr(`SMT_OFF_CON1, 32'h0);
        wr(`SMT_OFF_TMR, 32'h1);
        wr(`SMT_OFF_IRQ_STAT, 32'h1);
        rchk("rel_wr", `SMT_OFF_IRQ_STAT, 32'h0);
        chk("irq_off", 32'h0, {31'h0, irq});
        rst();
        wr(`SMT_OFF_CON1, 32'h86);
        u_smt_src_model.set_lv(1'b1, 1'b1);
        u_smt_src_model.burst(4);
        rchk("win_mode", `SMT_OFF_STAT, 32'hC0);
        wr(`SMT_OFF_CON0, 32'h10);
        u_smt_src_model.burst(4);
        rchk("win_pol", `SMT_OFF_STAT, 32'h80);
        wr(`SMT_OFF_CON0, 32'h0);
        wr(`SMT_OFF_CON1, 32'h80);
        u_smt_src_model.burst(4);
        rchk("sig_mode", `SMT_OFF_STAT, 32'hA0);
        wr(`SMT_OFF_CON0, 32'h8);
        u_smt_src_model.burst(4);
        rchk("sig_pol", `SMT_OFF_STAT, 32'h80);
        rst();
        wr(`SMT_OFF_CON0, 32'h4);
        wr(`SMT_OFF_CON1, 32'h89);
        u_smt_src_model.burst(4);
        rchk("clk_pol", `SMT_OFF_TMR, 32'h4);
        rchk("cap_mode", `SMT_OFF_STAT, 32'h80);
        give_verdict();
    end
endmodule // measurement_timer_core_test
`default_nettype wire
